// [src/master_shared_intensity.sv]
// Master and shared intensity PWM engine for seventeen open-drain outputs.
// Assumes a synchronous register port, an external blink timer that supplies
// the current phase, and individual intensity codes held elsewhere.
`timescale 1ns/10ps

module master_shared_intensity
  import led_intensity_pkg::*;
#(
  parameter int OUTPUTS = OUTPUT_COUNT,
  parameter logic [7:0] REG_RESET = MASTER_SHARED_RESET
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Configuration and blink state from neighbouring registers.
  input wire logic global_mode,
  input wire logic blink_enable,
  input wire logic blink_phase,
  input wire logic [OUTPUTS-1:0] phase0_bits,
  input wire logic [OUTPUTS-1:0] phase1_bits,
  input wire logic [(OUTPUTS-1)*CODE_WIDTH-1:0] individual_codes,
  // Open-drain outputs; the last one is the seventeenth output.
  output logic [OUTPUTS-1:0] port_out,
  output logic [OUTPUTS-1:0] port_oe
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // The master and shared intensity register.
  logic [7:0] intensity_q;
  // Registered read data.
  logic [7:0] rdata_q;
  // Address decode for the one register held here.
  wire logic addr_hit;
  // Field views of the stored value.
  wire logic [CODE_WIDTH-1:0] master_code;
  wire logic [CODE_WIDTH-1:0] shared_code;

  assign addr_hit = (reg_addr == MASTER_SHARED_ADDR);
  assign master_code = intensity_q[MASTER_FIELD_LSB +: CODE_WIDTH];
  assign shared_code = intensity_q[SHARED_FIELD_LSB +: CODE_WIDTH];

  // Writes land whole; both nibbles change in the same cycle so the
  // combined 8-bit control never shows a half-updated step.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      intensity_q <= REG_RESET;
    end else if (reg_wr && addr_hit) begin
      intensity_q <= reg_wdata;
    end
  end

  // A read answers one cycle later; unmapped addresses read as zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= UNMAPPED_READ_VALUE;
    end else if (reg_rd) begin
      rdata_q <= addr_hit ? intensity_q : UNMAPPED_READ_VALUE;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // PWM timebase
  // ----------------------------------------------------------------
  // Sub-tick counts 0..14 within a slot; slot counts 0..15 within a cycle.
  // The two together give 16 x 15 = 240 clock steps per PWM cycle.
  logic [3:0] sub_q;
  logic [3:0] slot_q;
  logic [3:0] sub_d;
  logic [3:0] slot_d;
  // The oscillator runs only for a nonzero master code.
  wire logic osc_run;
  // High in the first m of every fifteen sub-ticks.
  wire logic master_active;
  wire logic sub_wrap;

  assign osc_run = (master_code != MASTER_OFF);
  assign sub_wrap = (sub_q == SUB_TICK_LAST);
  assign master_active = osc_run && (sub_q < master_code);

  // Counters advance together; a stopped oscillator freezes both so no
  // output can toggle from the counters while the master code is zero.
  always_comb begin
    sub_d = sub_q;
    slot_d = slot_q;
    if (osc_run) begin
      sub_d = sub_wrap ? COUNT_RESET : 4'(sub_q + 4'h1);
      if (sub_wrap) begin
        slot_d = (slot_q == SLOT_LAST) ? COUNT_RESET : 4'(slot_q + 4'h1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sub_q <= COUNT_RESET;
      slot_q <= COUNT_RESET;
    end else begin
      sub_q <= sub_d;
      slot_q <= slot_d;
    end
  end

  // ----------------------------------------------------------------
  // Per-output code and level selection
  // ----------------------------------------------------------------
  // Selected code and on-time level of each output.
  wire logic [CODE_WIDTH-1:0] sel_code [OUTPUTS];
  wire logic [OUTPUTS-1:0] level_bit;
  // Next value of each open-drain enable.
  wire logic [OUTPUTS-1:0] drive_low_d;
  // Which phase register applies now.
  wire logic use_phase1;

  // With blinking off, only the phase-0 bits are looked at.
  assign use_phase1 = blink_enable && blink_phase;

  genvar gi;
  generate
    for (gi = 0; gi < OUTPUTS; gi++) begin : g_out
      // Global mode overrides every individual code, with no exceptions;
      // the last output always uses the shared nibble.
      if (gi == OUTPUTS - 1) begin : g_last
        assign sel_code[gi] = shared_code;
      end else begin : g_port
        assign sel_code[gi] = global_mode ? shared_code :
                              individual_codes[gi*CODE_WIDTH +: CODE_WIDTH];
      end
      assign level_bit[gi] = use_phase1 ? phase1_bits[gi] : phase0_bits[gi];

      pwm_slot_compare #(
        .CODE_W(CODE_WIDTH)
      ) u_cmp (
        .code(sel_code[gi]),
        .level_bit(level_bit[gi]),
        .slot(slot_q),
        .master_active(master_active),
        .drive_low(drive_low_d[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // Enables are registered so each pin changes on a clock edge only.
  // The pins are open drain, so the driven value is always zero.
  logic [OUTPUTS-1:0] oe_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      oe_q <= '0;
    end else begin
      oe_q <= drive_low_d;
    end
  end

  assign port_oe = oe_q;
  assign port_out = '0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Code of the seventeenth output and of the first port.
  wire logic [CODE_WIDTH-1:0] code_last;
  wire logic [CODE_WIDTH-1:0] code_first;

  assign code_last = sel_code[OUTPUTS-1];
  assign code_first = sel_code[0];

  a_write_fields: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == MASTER_SHARED_ADDR) |=> (intensity_q == $past(reg_wdata)))
    else $error("register write not stored");

  a_read_back: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == MASTER_SHARED_ADDR && !reg_wr) |=> (reg_rdata == $past(intensity_q)))
    else $error("read back differs from stored value");

  // The enables lag their inputs by one cycle, so the check only claims
  // stillness once the register and every input have held for a cycle.
  a_master_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
    (master_code == MASTER_OFF && $stable(intensity_q) && $stable(global_mode) && $stable(blink_enable)
     && $stable(blink_phase) && $stable(phase0_bits) && $stable(phase1_bits) && $stable(individual_codes))
    |=> ($stable(slot_q) && $stable(sub_q) && $stable(port_oe)))
    else $error("activity while master code is zero");

  a_sub_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    (osc_run && sub_q == SUB_TICK_LAST) |=> (sub_q == COUNT_RESET && slot_q != $past(slot_q)))
    else $error("slot did not advance after fifteen sub-ticks");

  a_master_offtime: assert property (@(posedge core_clk) disable iff (sys_rst)
    (osc_run && sub_q >= master_code && code_last != CODE_STATIC)
    |=> (port_oe[OUTPUTS-1] == $past(level_bit[OUTPUTS-1])))
    else $error("seventeenth output active during master off-time");

  a_slot_duty: assert property (@(posedge core_clk) disable iff (sys_rst)
    (master_active && code_last != CODE_STATIC && slot_q <= code_last)
    |=> (port_oe[OUTPUTS-1] == !$past(level_bit[OUTPUTS-1])))
    else $error("seventeenth output not at on level in its on slot");

  a_half_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    (master_active && code_last == 4'h7 && slot_q > 4'h7)
    |=> (port_oe[OUTPUTS-1] == $past(level_bit[OUTPUTS-1])))
    else $error("code seven not at off level in upper half");

  a_static_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    (code_last == CODE_STATIC) |=> (port_oe[OUTPUTS-1] == !$past(level_bit[OUTPUTS-1])))
    else $error("static code did not hold on level");

  a_global_same: assert property (@(posedge core_clk) disable iff (sys_rst)
    (global_mode && phase0_bits == '0 && !blink_enable) |=> (port_oe == '0 || port_oe == '1))
    else $error("outputs differ in global mode");

  a_individual_sel: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!global_mode && code_first == CODE_STATIC && !level_bit[0]) |=> port_oe[0])
    else $error("first port ignored its own static code");

endmodule : master_shared_intensity

// [src/led_intensity_pkg.sv]
// Constants shared by the master and shared intensity PWM logic.
// Assumes a single 200 MHz core clock and one 8-bit register port.
package led_intensity_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Byte address of the master and shared intensity register.
  localparam logic [7:0] MASTER_SHARED_ADDR = 8'h0E;
  // Master code field, bits 7 down to 4, most significant bit first.
  localparam int MASTER_FIELD_LSB = 4;
  // Shared code field, bits 3 down to 0, most significant bit first.
  localparam int SHARED_FIELD_LSB = 0;
  // Width of each intensity code field.
  localparam int CODE_WIDTH = 4;
  // Reset value of the register; the oscillator starts stopped.
  localparam logic [7:0] MASTER_SHARED_RESET = 8'h00;
  // Value returned for a read of an unmapped address.
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Intensity codes and PWM timing
  // ----------------------------------------------------------------
  // Intensity code that disables PWM and gives a static level.
  localparam logic [3:0] CODE_STATIC = 4'hF;
  // Master code that stops the oscillator.
  localparam logic [3:0] MASTER_OFF = 4'h0;
  // Last sub-tick of a slot: fifteen sub-ticks carry the master duty m/15.
  localparam logic [3:0] SUB_TICK_LAST = 4'hE;
  // Last slot of a PWM cycle: sixteen slots carry the output duty (n+1)/16.
  localparam logic [3:0] SLOT_LAST = 4'hF;
  // Reset value of both PWM counters.
  localparam logic [3:0] COUNT_RESET = 4'h0;
  // Number of PWM-capable outputs, the seventeenth included.
  localparam int OUTPUT_COUNT = 17;
  // Index of the seventeenth output.
  localparam int SEVENTEENTH_INDEX = 16;

endpackage : led_intensity_pkg

// [src/pwm_slot_compare.sv]
// One output's duty decision for the current PWM slot.
// Assumes the caller supplies the selected code, the blink-phase level bit
// and whether the current sub-tick lies in the master active time.
`timescale 1ns/10ps

module pwm_slot_compare
  import led_intensity_pkg::*;
#(
  parameter int CODE_W = CODE_WIDTH
) (
  // Selected intensity code and on-time level for this output.
  input wire logic [CODE_W-1:0] code,
  input wire logic level_bit,
  // Shared PWM timing.
  input wire logic [3:0] slot,
  input wire logic master_active,
  // Next value of the open-drain enable (high pulls the pin low).
  output logic drive_low
);

  // ----------------------------------------------------------------
  // Duty decision
  // ----------------------------------------------------------------
  // The output is in its on-time for slots 0..code, which gives (code+1)/16.
  wire logic in_on_slot;
  // Static code: no PWM at all, the level bit holds for the whole cycle.
  wire logic is_static;
  // Level driven in on-time: bit 0 pulls low, bit 1 releases the pin.
  wire logic on_drive;
  // Level driven in off-time is the opposite of the on-time level.
  wire logic off_drive;

  assign in_on_slot = (slot <= code);
  assign is_static = (code == CODE_STATIC);
  assign on_drive = ~level_bit;
  assign off_drive = level_bit;

  // Static codes ignore the master time; during master off-time every
  // PWM output rests at its off level so the pin never toggles there.
  assign drive_low = is_static ? on_drive :
                     (!master_active ? off_drive :
                     (in_on_slot ? on_drive : off_drive));

endmodule : pwm_slot_compare

// [test/led_load_model.sv]
// LED load model for the seventeen open-drain outputs.
// Assumes a pull-up behind every LED, so a released pin reads high.
`timescale 1ns/10ps

module led_load_model
  import led_intensity_pkg::*;
(
  // Pins as the design drives them.
  input wire logic [OUTPUT_COUNT-1:0] port_out,
  input wire logic [OUTPUT_COUNT-1:0] port_oe,
  // Level seen at each pin.
  output logic [OUTPUT_COUNT-1:0] pin_level
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // A released pin goes to the pull-up level, never to the last value.
  assign pin_level = (port_oe & port_out) | ~port_oe;
endmodule : led_load_model

// [test/tb.sv]
// Self-checking testbench for the master and shared intensity engine.
// Assumes the package, the design and the LED load model are compiled first.
`timescale 1ns/10ps

module tb;
  import led_intensity_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic global_mode = 1'b0;
  logic blink_enable = 1'b0;
  logic blink_phase = 1'b0;
  logic [16:0] phase0_bits = '0;
  logic [16:0] phase1_bits = '0;
  logic [63:0] individual_codes = '0;
  logic [16:0] port_out;
  logic [16:0] port_oe;
  logic [16:0] pin_level;
  int num_errors = 0;
  int tests_run = 0;
  // Corner settings: master, shared, global, blink, phase.
  logic [10:0] corner [6] = '{{4'h0, 4'h5, 3'b000}, {4'hF, 4'h7, 3'b111}, {4'hF, 4'hF, 3'b110},
                              {4'h1, 4'h0, 3'b011}, {4'hF, 4'hE, 3'b101}, {4'h7, 4'hF, 3'b000}};

  master_shared_intensity dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_mode(global_mode), .blink_enable(blink_enable), .blink_phase(blink_phase),
    .phase0_bits(phase0_bits), .phase1_bits(phase1_bits), .individual_codes(individual_codes),
    .port_out(port_out), .port_oe(port_oe));

  led_load_model load_u (.port_out(port_out), .port_oe(port_oe), .pin_level(pin_level));

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One register write; strobe raised and dropped on falling edges.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  // One register read; data is checked half a cycle after the taking edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check(what, exp, reg_rdata);
  endtask : rd

  // Low cycles per 240-clock PWM cycle; master off time sits at the off level.
  function automatic logic [7:0] exp_low(input logic [3:0] m, input logic [3:0] n, input logic b);
    int on;
    if (n == CODE_STATIC) return b ? 8'h00 : 8'hF0;
    on = int'(m) * (int'(n) + 1);
    return b ? 8'(240 - on) : 8'(on);
  endfunction : exp_low

  // Programs the register, then counts pin lows over one full PWM cycle.
  task automatic measure(input logic [3:0] m, input logic [3:0] g);
    logic [3:0] code;
    logic lvl;
    int low [17];
    wr(MASTER_SHARED_ADDR, {m, g});
    repeat (3) @(negedge core_clk);
    foreach (low[i]) low[i] = 0;
    repeat (240) begin
      @(negedge core_clk);
      foreach (low[i]) low[i] += int'(pin_level[i] === 1'b0);
    end
    for (int i = 0; i < 17; i++) begin
      if (i == 16 || global_mode) code = g;
      else code = individual_codes[4*i +: 4];
      lvl = (blink_enable && blink_phase) ? phase1_bits[i] : phase0_bits[i];
      check($sformatf("low count of output %0d", i), exp_low(m, code, lvl), 8'(low[i]));
    end
  endtask : measure

  // Verdict and end of run.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected 9k cycles of traffic.
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    void'($urandom(22));
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    rd(MASTER_SHARED_ADDR, MASTER_SHARED_RESET, "reset value");
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wr(MASTER_SHARED_ADDR, v);
      rd(MASTER_SHARED_ADDR, v, "readback");
    end
    // A write elsewhere must not land here, and unmapped reads give zero.
    wr(8'h0D, ~v);
    rd(MASTER_SHARED_ADDR, v, "after foreign write");
    rd(8'h0D, UNMAPPED_READ_VALUE, "unmapped read");
    $display("test register access done");
    // Corners first, then random settings, with global, blink and phase drawn at random too.
    for (int k = 0; k < 36; k++) begin
      @(negedge core_clk);
      // Corner 0 gives the first port a static code at its low level, and corner 4
      // clears every phase-0 bit in global mode, so the uniformity check really runs.
      phase0_bits = (k == 4) ? 17'h00000 : (17'($urandom) & ~17'(k == 0));
      phase1_bits = 17'($urandom);
      individual_codes = {$urandom, $urandom} | 64'(k == 0 ? 4'hF : 4'h0);
      v = 8'($urandom);
      if (k < 6) {v, global_mode, blink_enable, blink_phase} = corner[k];
      else {global_mode, blink_enable, blink_phase} = 3'($urandom);
      measure(v[7:4], v[3:0]);
    end
    $display("test pwm duty done");
    end_sim();
  end
endmodule : tb
